// File: msp_buf.sv
// Shared constants and types of the serial slave port, plus its rx buffer
//------------------------------------------------------------------------
// Constants and carriers
//------------------------------------------------------------------------
package msp_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int OVS = 16;                 // Samples per bit
	localparam int MAX_NODES = 32;
	// Command source codes
	localparam logic [7:0] SRC_PANEL = 8'h02;
	localparam logic [7:0] SRC_SERIAL = 8'h03;
	localparam logic [7:0] SRC_SLOT1 = 8'h04;
	localparam logic [7:0] SRC_SLOT2 = 8'h05;
	// Bit rate codes
	localparam logic [7:0] BAUD_TEST = 8'h02;
	localparam logic [7:0] BAUD_2400 = 8'h03;
	localparam logic [7:0] BAUD_4800 = 8'h04;
	localparam logic [7:0] BAUD_9600 = 8'h05;
	localparam logic [7:0] BAUD_19200 = 8'h06;
	localparam logic [11:0] DIV_TEST = 12'h004;
	localparam logic [11:0] DIV_2400 = 12'(CLK_HZ / (2400 * OVS));
	localparam logic [11:0] DIV_4800 = 12'(CLK_HZ / (4800 * OVS));
	localparam logic [11:0] DIV_9600 = 12'(CLK_HZ / (9600 * OVS));
	localparam logic [11:0] DIV_19200 = 12'(CLK_HZ / (19200 * OVS));
	// Character format codes
	localparam logic [7:0] LEN_7 = 8'h07;
	localparam logic [7:0] LEN_8 = 8'h08;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [7:0] STOP_1 = 8'h01;
	localparam logic [7:0] STOP_2 = 8'h02;
	// Node address range and end of message character
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'(MAX_NODES);
	localparam logic [7:0] EOM_CHAR = 8'h0D;
	// Reply wait: counted in units of 0.1 ms, up to 1000 ms
	localparam int WAIT_UNIT_NS = 100_000;
	localparam int WAIT_UNIT_CYC_DEF = WAIT_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [13:0] WAIT_MAX = 14'h2710;
	// Bit timing points within one bit
	localparam logic [3:0] PH_MID = 4'h7;
	localparam logic [3:0] PH_END = 4'hF;

	typedef struct packed {
		logic [11:0] div;
		logic eight;
		logic [1:0] par;
		logic two_stop;
	} msp_cfg_t;

	localparam msp_cfg_t CFG_RST = '{div: DIV_4800, eight: 1'b0,
		par: PAR_NONE, two_stop: 1'b0};
endpackage

`timescale 1ns/100ps
//------------------------------------------------------------------------
// Two-entry buffer, valid/ready on both sides
//------------------------------------------------------------------------
module msp_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [W-1:0] s_data,
	// Drain side
	output logic m_valid,
	input wire logic m_ready,
	output logic [W-1:0] m_data
);
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Full and empty come straight from the entry count
	assign s_ready = (cnt_r != 2'h2);
	assign push = s_valid && s_ready;
	assign pop = m_valid && m_ready;

	// Pointer and count update
	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = s_data;
			wp_nxt = !wp_r;
		end
		if (pop) begin
			rp_nxt = !rp_r;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
			m_valid <= 1'b0;
			m_data <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			// Drain side kept in flops so it leaves the port glitch free
			m_valid <= (cnt_nxt != 2'h0);
			m_data <= mem_nxt[rp_nxt];
		end
	end
endmodule // msp_buf

// File: msp_host.sv
// Behavioural bus master on the shared serial line
`timescale 1ns/100ps
//--------------------
// Master model
//--------------------
module msp_host #(
	parameter int BIT_CYC = 64
) (
	// Clock
	input wire logic ref_clk,
	// Shared line and our driver onto it
	input wire logic line,
	output logic drv
);
	int nbits = 8;
	int par = 0;
	int stops = 1;

	// Released driver reads as the bus pull-up level
	initial drv = 1'h1;

	// One bit, changed just after an edge
	task automatic put(input logic b);
		drv = b;
		repeat (BIT_CYC) @(posedge ref_clk);
		#1;
	endtask

	// Master opens every exchange, same format as the slave
	task automatic send(input logic [7:0] d, input logic bad);
		logic p;
		p = (par == 2) ^ bad;
		@(posedge ref_clk);
		#1;
		put(1'h0);
		for (int i = 0; i < nbits; i++) begin
			put(d[i]);
			p ^= d[i];
		end
		if (par != 0)
			put(p);
		repeat (stops) put(1'h1);
	endtask

	// Sample a reply at bit middles; ok covers start, parity, stops
	task automatic recv(output logic [7:0] d, output logic ok);
		int n;
		d = 8'h00;
		n = 0;
		while (line !== 1'h0 && n < 40 * BIT_CYC) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		ok = (line === 1'h0);
		for (int i = 0; i < nbits; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			d[i] = line;
		end
		if (par != 0) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			ok &= (line === ((^d) ^ (par == 2)));
		end
		repeat (stops) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			ok &= (line === 1'h1);
		end
	endtask
endmodule // msp_host

// File: msp_port.sv
// Multidrop serial slave port: rx/tx engine, addressing and reply wait
`timescale 1ns/100ps
module msp_port import msp_pkg::*; #(
	parameter int WAIT_UNIT_CYC = WAIT_UNIT_CYC_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Configuration settings
	input wire logic [7:0] command_source_select,
	input wire logic [7:0] bit_rate_select,
	input wire logic [7:0] node_address_setting,
	input wire logic [7:0] char_length_select,
	input wire logic [7:0] parity_select,
	input wire logic [7:0] stop_bit_select,
	input wire logic [13:0] reply_wait_time,
	// Line pins
	input wire logic rxd_pin,
	output logic txd_o,
	output logic txd_oe,
	// Received payload stream
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	// Reply stream
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	// Status
	output logic msg_done,
	output logic overrun,
	output logic char_err,
	output logic [3:0] cmd_src,
	output logic serial_cmd_en
);
	typedef enum {R_IDLE, R_START, R_BITS, R_STOP} msp_rx_t;
	typedef enum {M_ADDR, M_BODY, M_SKIP, M_WAIT, M_REPLY} msp_msg_t;

	// Data plus parity bits of one character
	function automatic logic [3:0] frame_bits(input msp_cfg_t c);
		frame_bits = (c.eight ? 4'h8 : 4'h7) + {3'h0, c.par != PAR_NONE};
	endfunction

	// Parity bit that goes with a character
	function automatic logic par_bit(input msp_cfg_t c, input logic [7:0] d);
		logic x;
		x = c.eight ? ^d : ^d[6:0];
		par_bit = (c.par == PAR_ODD) ? !x : x;
	endfunction

	//--------------------------------------------------------------------
	// Pin sync, configuration and baud divider
	//--------------------------------------------------------------------
	logic rxd_s1_r, rxd_s2_r;
	msp_cfg_t cfg_r, cfg_nxt;
	logic [3:0] cmd_src_nxt;
	logic [11:0] div_r, div_nxt;
	logic tick;
	msp_rx_t rx_st_r, rx_st_nxt;
	logic tx_busy_r, tx_busy_nxt;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
		end else begin
			rxd_s1_r <= rxd_pin;
			rxd_s2_r <= rxd_s1_r;
		end
	end

	// Format changes only between characters, so no frame is cut in two
	always_comb begin
		cfg_nxt = cfg_r;
		if (rx_st_r == R_IDLE && !tx_busy_r) begin
			case (bit_rate_select)
				BAUD_TEST: cfg_nxt.div = DIV_TEST;
				BAUD_2400: cfg_nxt.div = DIV_2400;
				BAUD_9600: cfg_nxt.div = DIV_9600;
				BAUD_19200: cfg_nxt.div = DIV_19200;
				default: cfg_nxt.div = DIV_4800;
			endcase
			cfg_nxt.eight = (char_length_select == LEN_8);
			cfg_nxt.par = (parity_select[7:2] == '0 && parity_select[1:0]
				!= 2'h3) ? parity_select[1:0] : PAR_NONE;
			cfg_nxt.two_stop = (stop_bit_select == STOP_2);
		end
		case (command_source_select)
			SRC_SERIAL: cmd_src_nxt = 4'h2;
			SRC_SLOT1: cmd_src_nxt = 4'h4;
			SRC_SLOT2: cmd_src_nxt = 4'h8;
			default: cmd_src_nxt = 4'h1;
		endcase
		tick = (div_r == 12'h000);
		div_nxt = tick ? cfg_r.div - 12'h001 : div_r - 12'h001;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= CFG_RST;
			cmd_src <= 4'h1;
			serial_cmd_en <= 1'b0;
			div_r <= 12'h000;
		end else begin
			cfg_r <= cfg_nxt;
			cmd_src <= cmd_src_nxt;
			serial_cmd_en <= cmd_src_nxt[1];
			div_r <= div_nxt;
		end
	end

	//--------------------------------------------------------------------
	// Receiver, sampling each bit at its middle
	//--------------------------------------------------------------------
	logic [3:0] rx_ph_r, rx_ph_nxt, rx_i_r, rx_i_nxt;
	logic [8:0] rx_sh_r, rx_sh_nxt;
	logic ch_v_r, ch_v_nxt, ch_perr_r, ch_perr_nxt, ch_ferr_r, ch_ferr_nxt;
	logic [7:0] ch_data_r, ch_data_nxt;

	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_ph_nxt = rx_ph_r;
		rx_i_nxt = rx_i_r;
		rx_sh_nxt = rx_sh_r;
		ch_v_nxt = 1'b0;
		ch_perr_nxt = ch_perr_r;
		ch_ferr_nxt = ch_ferr_r;
		ch_data_nxt = ch_data_r;
		if (tick && rx_st_r != R_IDLE) begin
			rx_ph_nxt = rx_ph_r + 4'h1;
		end
		case (rx_st_r)
			R_IDLE: begin
				rx_ph_nxt = 4'h0;
				if (!rxd_s2_r) begin
					rx_st_nxt = R_START;
				end
			end
			R_START: begin
				// A glitch shorter than half a bit is not a start
				if (tick && rx_ph_r == PH_MID) begin
					rx_st_nxt = rxd_s2_r ? R_IDLE : R_BITS;
					rx_ph_nxt = 4'h0;
					rx_i_nxt = 4'h0;
				end
			end
			R_BITS: begin
				if (tick && rx_ph_r == PH_END) begin
					rx_sh_nxt[rx_i_r] = rxd_s2_r;
					rx_i_nxt = rx_i_r + 4'h1;
					if (rx_i_r == frame_bits(cfg_r) - 4'h1) begin
						rx_st_nxt = R_STOP;
					end
				end
			end
			R_STOP: begin
				// Only the first stop bit is checked
				if (tick && rx_ph_r == PH_END) begin
					rx_st_nxt = R_IDLE;
					ch_v_nxt = 1'b1;
					ch_ferr_nxt = !rxd_s2_r;
					ch_data_nxt = cfg_r.eight ? rx_sh_r[7:0]
						: {1'b0, rx_sh_r[6:0]};
					ch_perr_nxt = (cfg_r.par != PAR_NONE) &&
						(par_bit(cfg_r, ch_data_nxt) !=
						(cfg_r.eight ? rx_sh_r[8] : rx_sh_r[7]));
				end
			end
			default: rx_st_nxt = R_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= R_IDLE;
			rx_ph_r <= 4'h0;
			rx_i_r <= 4'h0;
			rx_sh_r <= '0;
			ch_v_r <= 1'b0;
			ch_perr_r <= 1'b0;
			ch_ferr_r <= 1'b0;
			ch_data_r <= 8'h00;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_ph_r <= rx_ph_nxt;
			rx_i_r <= rx_i_nxt;
			rx_sh_r <= rx_sh_nxt;
			ch_v_r <= ch_v_nxt;
			ch_perr_r <= ch_perr_nxt;
			ch_ferr_r <= ch_ferr_nxt;
			ch_data_r <= ch_data_nxt;
		end
	end

	//--------------------------------------------------------------------
	// Message filter and reply wait
	//--------------------------------------------------------------------
	msp_msg_t msg_r, msg_nxt;
	logic [13:0] wait_left_r, wait_left_nxt, unit_r, unit_nxt;
	logic ch_good, addr_hit, push, buf_ready, tx_fin_last;
	logic msg_done_nxt, overrun_nxt, char_err_nxt;

	always_comb begin
		ch_good = ch_v_r && !ch_perr_r && !ch_ferr_r;
		addr_hit = ch_data_r == node_address_setting &&
			node_address_setting >= ADDR_MIN &&
			node_address_setting <= ADDR_MAX;
		push = (msg_r == M_BODY) && ch_good && ch_data_r != EOM_CHAR;
		msg_nxt = msg_r;
		wait_left_nxt = wait_left_r;
		unit_nxt = unit_r;
		msg_done_nxt = 1'b0;
		overrun_nxt = push && !buf_ready;
		char_err_nxt = ch_v_r && !ch_good && msg_r != M_WAIT
			&& msg_r != M_REPLY;
		case (msg_r)
			// Another node's message is skipped to its end
			M_ADDR: if (ch_good) begin
				msg_nxt = addr_hit ? M_BODY : M_SKIP;
			end
			M_BODY: if (ch_v_r) begin
				if (!ch_good) begin
					msg_nxt = M_SKIP;
				end else if (ch_data_r == EOM_CHAR) begin
					msg_nxt = M_WAIT;
					msg_done_nxt = 1'b1;
					wait_left_nxt = (reply_wait_time > WAIT_MAX) ?
						WAIT_MAX : reply_wait_time;
					unit_nxt = 14'h0000;
				end
			end
			M_SKIP: if (ch_good && ch_data_r == EOM_CHAR) begin
				msg_nxt = M_ADDR;
			end
			M_WAIT: begin
				if (wait_left_r == 14'h0000) begin
					msg_nxt = M_REPLY;
				end else if (unit_r == 14'(WAIT_UNIT_CYC - 1)) begin
					unit_nxt = 14'h0000;
					wait_left_nxt = wait_left_r - 14'h0001;
				end else begin
					unit_nxt = unit_r + 14'h0001;
				end
			end
			// Our own echo on the line is ignored while replying
			M_REPLY: if (tx_fin_last) begin
				msg_nxt = M_ADDR;
			end
			default: msg_nxt = M_ADDR;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg_r <= M_ADDR;
			wait_left_r <= 14'h0000;
			unit_r <= 14'h0000;
			msg_done <= 1'b0;
			overrun <= 1'b0;
			char_err <= 1'b0;
		end else begin
			msg_r <= msg_nxt;
			wait_left_r <= wait_left_nxt;
			unit_r <= unit_nxt;
			msg_done <= msg_done_nxt;
			overrun <= overrun_nxt;
			char_err <= char_err_nxt;
		end
	end

	// The receiver cannot pause the line, so a full buffer shows overrun
	msp_buf #(.W(8)) u_rx_buf (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.s_valid(push),
		.s_ready(buf_ready),
		.s_data(ch_data_r),
		.m_valid(rx_valid),
		.m_ready(rx_ready),
		.m_data(rx_data)
	);

	//--------------------------------------------------------------------
	// Transmitter, only inside the reply window
	//--------------------------------------------------------------------
	logic [11:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_ph_r, tx_ph_nxt;
	logic tx_lastc_r, tx_lastc_nxt, tx_acc, tx_ready_nxt;
	logic [3:0] nd;

	// Kept apart from the process below, which reads the next message state
	assign tx_fin_last = tx_busy_r && tick && tx_ph_r == PH_END &&
		tx_cnt_r == 4'h1 && tx_lastc_r;

	always_comb begin
		tx_acc = tx_valid && tx_ready;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_ph_nxt = tx_ph_r;
		tx_busy_nxt = tx_busy_r;
		tx_lastc_nxt = tx_lastc_r;
		nd = cfg_r.eight ? 4'h8 : 4'h7;
		if (tx_acc) begin
			// Frame LSB first: start, data, parity, then stop ones
			tx_sh_nxt = '1;
			tx_sh_nxt[0] = 1'b0;
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < nd) begin
					tx_sh_nxt[i + 1] = tx_data[i];
				end
			end
			if (cfg_r.par != PAR_NONE) begin
				tx_sh_nxt[nd + 4'h1] = par_bit(cfg_r, tx_data);
			end
			tx_cnt_nxt = 4'h2 + frame_bits(cfg_r)
				+ {3'h0, cfg_r.two_stop};
			tx_ph_nxt = 4'h0;
			tx_busy_nxt = 1'b1;
			tx_lastc_nxt = tx_last;
		end else if (tx_busy_r && tick) begin
			tx_ph_nxt = tx_ph_r + 4'h1;
			if (tx_ph_r == PH_END) begin
				tx_sh_nxt = {1'b1, tx_sh_r[11:1]};
				tx_cnt_nxt = tx_cnt_r - 4'h1;
				tx_busy_nxt = (tx_cnt_r != 4'h1);
			end
		end
		// Never speak unasked: ready only after the wait has run out
		tx_ready_nxt = (msg_nxt == M_REPLY) && !tx_busy_nxt;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_r <= '1;
			tx_cnt_r <= 4'h0;
			tx_ph_r <= 4'h0;
			tx_busy_r <= 1'b0;
			tx_lastc_r <= 1'b0;
			tx_ready <= 1'b0;
			txd_o <= 1'b1;
			txd_oe <= 1'b0;
		end else begin
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_ph_r <= tx_ph_nxt;
			tx_busy_r <= tx_busy_nxt;
			tx_lastc_r <= tx_lastc_nxt;
			tx_ready <= tx_ready_nxt;
			txd_o <= tx_busy_nxt ? tx_sh_nxt[0] : 1'b1;
			txd_oe <= tx_busy_nxt;
		end
	end

	//--------------------------------------------------------------------
	// Assertions and covers
	//--------------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_FOREIGN_SKIPPED: assert property (
		msg_r == M_ADDR && ch_good && ch_data_r != node_address_setting
		|=> msg_r == M_SKIP) else $error("foreign message not skipped");
	AST_DRIVE_ONLY_REPLY: assert property (
		txd_oe |-> msg_r == M_REPLY || $past(msg_r) == M_REPLY)
		else $error("line driven outside reply window");
	AST_RATE_4800: assert property (
		rx_st_r == R_IDLE && !tx_busy_r && bit_rate_select == BAUD_4800
		|=> cfg_r.div == DIV_4800) else $error("bit rate code not applied");
	AST_SRC_SERIAL: assert property (
		command_source_select == SRC_SERIAL |=> cmd_src == 4'h2
		&& serial_cmd_en) else $error("serial command source not selected");
	AST_ADDR_ZERO: assert property (
		msg_r == M_ADDR && ch_good && ch_data_r == 8'h00
		|=> msg_r != M_BODY) else $error("address zero accepted");
	AST_LEN7_FRAME: assert property (
		tx_acc && !cfg_r.eight && cfg_r.par == PAR_NONE && !cfg_r.two_stop
		|=> tx_cnt_r == 4'h9) else $error("7N1 frame length wrong");
	AST_TWO_STOP: assert property (
		tx_acc && cfg_r.eight && cfg_r.par != PAR_NONE && cfg_r.two_stop
		|=> tx_cnt_r == 4'hC) else $error("8P2 frame length wrong");
	AST_NO_PAR_ERR: assert property (
		ch_v_r && cfg_r.par == PAR_NONE |-> !ch_perr_r)
		else $error("parity error without parity");
	AST_ZERO_WAIT: assert property (
		msg_r == M_BODY && ch_good && ch_data_r == EOM_CHAR &&
		reply_wait_time == 14'h0000 |=> msg_r == M_WAIT
		##1 msg_r == M_REPLY && tx_ready)
		else $error("zero wait reply late");
	AST_WAIT_QUIET: assert property (
		msg_r == M_WAIT |-> !txd_oe && !tx_ready)
		else $error("reply before wait ended");

	COV_ADDRESSED: cover property (msg_r == M_ADDR ##1 msg_r == M_BODY);
	COV_REPLY: cover property (msg_r == M_WAIT ##1 msg_r == M_REPLY);
	COV_LAST_SENT: cover property (tx_fin_last);
	COV_OVERRUN: cover property (overrun);
endmodule // msp_port

// File: msp_port_tb.sv
// Self-checking bench for the serial slave port
`timescale 1ns/100ps
module msp_port_tb import msp_pkg::*; ;
	localparam int UNIT = 4;
	localparam int BIT = 64;
	logic ref_clk, rst_n, rx_ready, tx_valid, tx_last, txd_o, txd_oe;
	logic rx_valid, tx_ready, msg_done, overrun, char_err, sc_en;
	logic host_drv, line, rdy_q;
	logic [7:0] src, rate, addr, len, par, stp, tx_data, rx_data;
	logic [13:0] wt;
	logic [3:0] cmd_src;
	logic [7:0] rxq[$];
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_done = 0;
	int n_ovr = 0;
	int n_err = 0;
	int t_done = 0;
	int t_rdy = 0;

	// Released line is held high by the pull-up
	assign line = txd_oe ? txd_o : host_drv;

	msp_port #(.WAIT_UNIT_CYC(UNIT)) i_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .command_source_select(src),
		.bit_rate_select(rate), .node_address_setting(addr),
		.char_length_select(len), .parity_select(par),
		.stop_bit_select(stp), .reply_wait_time(wt), .rxd_pin(line),
		.txd_o(txd_o), .txd_oe(txd_oe), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
		.msg_done(msg_done), .overrun(overrun), .char_err(char_err),
		.cmd_src(cmd_src), .serial_cmd_en(sc_en));

	msp_host #(.BIT_CYC(BIT)) i_host (.ref_clk(ref_clk), .line(line),
		.drv(host_drv));

	// Clock
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Collect stream words and pulses; cut a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'h1 && rx_ready === 1'h1)
			rxq.push_back(rx_data);
		if (msg_done === 1'h1) begin
			n_done <= n_done + 1;
			t_done <= cyc;
		end
		if (overrun === 1'h1)
			n_ovr <= n_ovr + 1;
		if (char_err === 1'h1)
			n_err <= n_err + 1;
		if (tx_ready === 1'h1 && rdy_q !== 1'h1)
			t_rdy <= cyc;
		rdy_q <= tx_ready;
		if (cyc == 60000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Same format on both ends, or frames would be misread
	task automatic fmt(input logic [7:0] l, p, s);
		len = l;
		par = p;
		stp = s;
		i_host.nbits = (l == LEN_8) ? 8 : 7;
		i_host.par = int'(p);
		i_host.stops = (s == STOP_2) ? 2 : 1;
		tick(2);
	endtask

	// Address, payload, end of message
	task automatic msg(input logic [7:0] a, input logic [7:0] d[3],
		input int n, input logic bad);
		i_host.send(a, 1'h0);
		for (int i = 0; i < n; i++)
			i_host.send(d[i], bad);
		i_host.send(EOM_CHAR, 1'h0);
		tick(40);
	endtask

	// One reply char through the handshake, judged at the master
	task automatic reply(input logic [7:0] d, input logic last);
		logic [7:0] got;
		logic ok;
		int n;
		n = 0;
		tx_valid = 1'h1;
		tx_data = d;
		tx_last = last;
		// Ready is looked at between edges; the next edge takes the char
		while (tx_ready !== 1'h1 && n < 2000) begin
			tick(1);
			n++;
		end
		tick(1);
		tx_valid = 1'h0;
		i_host.recv(got, ok);
		check(got, len == LEN_8 ? d : {1'h0, d[6:0]});
		check(8'(ok), 8'h01);
		tick(BIT);
		check(8'(txd_oe), 8'h00);
	endtask

	task automatic t_reset();
		check(8'(cmd_src), 8'h01);
		check(8'(sc_en), 8'h00);
		check(8'(txd_oe), 8'h00);
		check(8'(txd_o), 8'h01);
		check(8'(tx_ready), 8'h00);
		$display("t_reset done");
	endtask

	task automatic t_src();
		logic [7:0] c[5] = '{SRC_PANEL, SRC_SERIAL, SRC_SLOT1,
			SRC_SLOT2, 8'h09};
		logic [3:0] e[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
		for (int i = 0; i < 5; i++) begin
			src = c[i];
			tick(2);
			check(8'(cmd_src), 8'(e[i]));
			check(8'(sc_en), 8'(e[i][1]));
		end
		// Visit the default rate; the divider needs a whole slow period
		// before it falls back to the fast test rate
		rate = BAUD_4800;
		tick(2);
		rate = BAUD_TEST;
		tick(1700);
		$display("t_src done");
	endtask

	// Addressed message, wait, then two reply chars; odd parity uses 2 stops
	task automatic t_msg(input logic [13:0] w, input logic [7:0] p);
		int d0;
		wt = w;
		fmt(LEN_8, p, (p == 8'h02) ? STOP_2 : STOP_1);
		d0 = n_done;
		msg(8'h05, '{8'hA5, 8'h3C, 8'h00}, 2, 1'h0);
		check(8'(n_done - d0), 8'h01);
		check(8'(rxq.size()), 8'h02);
		check(rxq.pop_front(), 8'hA5);
		check(rxq.pop_front(), 8'h3C);
		check(8'(t_rdy - t_done >= w * UNIT &&
			t_rdy - t_done <= w * UNIT + 2), 8'h01);
		reply(8'h96, 1'h0);
		reply(8'h5A, 1'h1);
		check(8'(tx_ready), 8'h00);
		$display("t_msg done");
	endtask

	// Foreign address ignored; top address 32 accepted
	task automatic t_other();
		int d0;
		addr = 8'h20;
		tick(2);
		d0 = n_done;
		msg(8'h07, '{8'h11, 8'h22, 8'h00}, 2, 1'h0);
		check(8'(n_done - d0), 8'h00);
		check(8'(rxq.size()), 8'h00);
		check(8'(tx_ready), 8'h00);
		msg(8'h20, '{8'h33, 8'h00, 8'h00}, 1, 1'h0);
		check(8'(n_done - d0), 8'h01);
		check(rxq.pop_front(), 8'h33);
		reply(8'h44, 1'h1);
		addr = 8'h05;
		$display("t_other done");
	endtask

	// Seven data bits, even parity, two stops; bad parity flagged
	task automatic t_par();
		int e0;
		fmt(LEN_7, 8'h01, STOP_2);
		e0 = n_err;
		msg(8'h05, '{8'hC5, 8'h00, 8'h00}, 1, 1'h1);
		check(8'(n_err - e0), 8'h01);
		msg(8'h05, '{8'hC5, 8'h00, 8'h00}, 1, 1'h0);
		check(8'(rxq.size()), 8'h01);
		check(rxq.pop_front(), 8'h45);
		reply(8'hC5, 1'h1);
		$display("t_par done");
	endtask

	// Reader stalls under 7N1: third word overruns, two survive
	task automatic t_ovr();
		int o0;
		fmt(LEN_7, 8'h00, STOP_1);
		rx_ready = 1'h0;
		o0 = n_ovr;
		msg(8'h05, '{8'h01, 8'h02, 8'h03}, 3, 1'h0);
		check(8'(n_ovr - o0), 8'h01);
		rx_ready = 1'h1;
		tick(4);
		check(8'(rxq.size()), 8'h02);
		check(rxq.pop_front(), 8'h01);
		check(rxq.pop_front(), 8'h02);
		reply(8'h00, 1'h1);
		$display("t_ovr done");
	endtask

	// Main sequence
	initial begin
		rst_n = 1'h0;
		src = SRC_PANEL;
		rate = BAUD_TEST;
		addr = 8'h05;
		len = LEN_8;
		par = 8'h00;
		stp = STOP_1;
		wt = 14'h0;
		rx_ready = 1'h1;
		tx_valid = 1'h0;
		tx_data = 8'h00;
		tx_last = 1'h0;
		tick(20);
		rst_n = 1'h1;
		tick(2);
		t_reset();
		t_src();
		t_msg(14'h0, 8'h00);
		t_msg(14'h3, 8'h02);
		t_other();
		t_par();
		t_ovr();
		tally_and_finish();
	end
endmodule // msp_port_tb
